// ---- inc/irq_ctrl_pkg.sv ----
// constants, register map and state type of the multilevel interrupt controller
// assumes: single pclk domain, registers reached over APB with 32-bit data
package irq_ctrl_pkg;

   // ----------------------------------------------------------------
   // source counts and vector numbering
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 8;
   localparam int NUM_NMI = 2;
   localparam logic [7:0] RESET_VEC = 8'h00;
   localparam logic [7:0] NMI_VEC_BASE = 8'h01;
   localparam logic [7:0] SRC_VEC_BASE = 8'h03;

   // ----------------------------------------------------------------
   // level codes
   // ----------------------------------------------------------------
   localparam logic [1:0] LVL_OFF = 2'h0;
   localparam logic [1:0] LVL_LOW = 2'h1;
   localparam logic [1:0] LVL_MED = 2'h2;
   localparam logic [1:0] LVL_HIGH = 2'h3;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_STATUS_IDX = 8'h00;
   localparam logic [7:0] REG_PRIO_IDX = 8'h01;
   localparam logic [7:0] REG_CTRL_IDX = 8'h02;
   localparam logic [7:0] REG_PEND_IDX = 8'h03;
   localparam logic [7:0] REG_SRCEN_IDX = 8'h04;
   localparam logic [7:0] REG_SRCLVL_IDX = 8'h05;
   localparam logic [7:0] REG_CLRMODE_IDX = 8'h06;
   localparam logic [7:0] REG_NMIEN_IDX = 8'h07;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_RR_BIT = 7;
   localparam int CTRL_HIGH_BIT = 2;
   localparam int CTRL_MED_BIT = 1;
   localparam int CTRL_LOW_BIT = 0;
   localparam int STATUS_NMI_BIT = 7;
   localparam int CLRMODE_ACC_LSB = 8;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PRIO_RST = 8'h00;
   localparam logic [7:0] SRCEN_RST = 8'h00;
   localparam logic [15:0] SRCLVL_RST = 16'h0000;
   localparam logic [7:0] AUTOCLR_RST = 8'hFF;
   localparam logic [7:0] ACCCLR_RST = 8'h00;
   localparam logic [1:0] NMIEN_RST = 2'h0;

   // ----------------------------------------------------------------
   // cycle counts
   // ----------------------------------------------------------------
   localparam logic [7:0] PUSH_CYC = 8'h02;
   localparam logic [7:0] JUMP_CYC = 8'h03;
   localparam logic [7:0] WAKE_EXTRA_CYC = 8'h05;
   localparam logic [7:0] RET_CYC_NARROW = 8'h04;
   localparam logic [7:0] RET_CYC_WIDE = 8'h05;
   localparam logic [2:0] CCP_BLOCK_CYC = 3'h4;

   // ----------------------------------------------------------------
   // entry and return sequencer
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_WAKE, ST_PUSH, ST_JUMP, ST_RET} seq_state_t;

endpackage

// ---- rtl/multilevel_irq_ctrl.sv ----
// multilevel interrupt controller: pending flags, level arbitration, entry/return timing
// assumes: core strobes and source conditions are synchronous to pclk; APB slave
// How it works
// - each source carries a two-bit level: off, low, medium, high
// - medium preempts low handlers; high preempts medium and low handlers
// - same level: lowest vector wins unless low-level round robin is on
// - optional round robin applies only among low-level requests
// - maskable acknowledge needs global enable; acknowledge never alters it
// - acknowledge also needs the level enable and the source enable
// - each request is compared with running level; acknowledged or kept pending
// - after a return one instruction completes before the next acknowledge
// - executing flags restore prior level on interrupt return; status not saved
// - reset vector is zero; every source has its own higher vector
// - pending flag sets on its condition even while disabled
// - flags clear on vector entry, on write one, or on register read
// - pending flags are kept until the request may win
// - acknowledge is blocked while code runs from a locked section
// - a correct unlock signature blocks interrupts for four cycles
// - enabled nonmaskable sources ignore the global enable and never change it
// - nonmaskable handler is never preempted; lowest nonmaskable vector first
// - entry takes two cycles to the vector, then three to the handler
// - a multicycle instruction completes before entry starts
// - waking from sleep adds five cycles plus the wake time
// - return takes four or five cycles by program counter width
// - after a nested return the interrupted handler level resumes
// - round robin stores last low vector and gives it lowest priority
// - clearing a level enable takes effect one cycle later
// - one executing flag per level plus nonmaskable, cleared on return
//
// Design decisions made here: register access over APB and the address map.
module multilevel_irq_ctrl #(
   parameter logic [7:0] SLEEP_WAKE_CYC = 8'h06,
   parameter bit PC_WIDE = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [9:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] irq_cond,
   input wire logic [irq_ctrl_pkg::NUM_NMI-1:0] nmi_cond,
   input wire logic core_gie,
   input wire logic core_instr_done,
   input wire logic core_irq_return_instr,
   input wire logic core_lock_exec,
   input wire logic core_ccp_unlock,
   input wire logic core_sleep,
   output logic irq_ack,
   output logic [7:0] irq_vec,
   output logic pc_load,
   output logic [15:0] vec_addr,
   output logic handler_start,
   output logic ret_done,
   output logic seq_busy
);
   localparam int N = irq_ctrl_pkg::NUM_SRC;
   localparam int RET_DLY = PC_WIDE ? 6 : 5;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q, prio_q, src_en_q, autoclr_q, accclr_q;
   logic [15:0] src_lvl_q;
   logic [1:0] nmi_en_q, nmi_pend_q;
   logic [N-1:0] pend_q;
   logic [2:0] lvl_en_dly_q;
   logic [3:0] exec_q; // [3]=nonmaskable, [2]=high, [1]=medium, [0]=low
   logic after_ret_q;
   logic [2:0] ccp_cnt_q;
   irq_ctrl_pkg::seq_state_t state_q;
   logic [7:0] cnt_q, vec_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, ack_q, pc_load_q, start_q, ret_done_q;

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic [7:0] idx;
   logic hit, wr_done, rd_done;
   logic [31:0] rd_val;
   assign idx = paddr[9:2];
   assign hit = idx <= irq_ctrl_pkg::REG_NMIEN_IDX;
   assign wr_done = psel & penable & pready_q & pwrite & hit;
   assign rd_done = psel & penable & pready_q & ~pwrite & hit;

   // read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      case (idx)
         irq_ctrl_pkg::REG_STATUS_IDX: rd_val[7:0] = {exec_q[3], 4'h0, exec_q[2:0]};
         irq_ctrl_pkg::REG_PRIO_IDX: rd_val[7:0] = prio_q;
         irq_ctrl_pkg::REG_CTRL_IDX: rd_val[7:0] = ctrl_q;
         irq_ctrl_pkg::REG_PEND_IDX: rd_val[N-1:0] = pend_q;
         irq_ctrl_pkg::REG_SRCEN_IDX: rd_val[7:0] = src_en_q;
         irq_ctrl_pkg::REG_SRCLVL_IDX: rd_val[15:0] = src_lvl_q;
         irq_ctrl_pkg::REG_CLRMODE_IDX: rd_val[15:0] = {accclr_q, autoclr_q};
         irq_ctrl_pkg::REG_NMIEN_IDX: rd_val[1:0] = nmi_en_q;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // no wait state: answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel & ~penable;
         pslverr_q <= psel & ~penable & ~hit;
         if (psel && !penable) begin
            prdata_q <= rd_val;
         end
      end
   end

   // software-written configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= irq_ctrl_pkg::CTRL_RST;
         src_en_q <= irq_ctrl_pkg::SRCEN_RST;
         src_lvl_q <= irq_ctrl_pkg::SRCLVL_RST;
         autoclr_q <= irq_ctrl_pkg::AUTOCLR_RST;
         accclr_q <= irq_ctrl_pkg::ACCCLR_RST;
         nmi_en_q <= irq_ctrl_pkg::NMIEN_RST;
      end else if (wr_done) begin
         case (idx)
            irq_ctrl_pkg::REG_CTRL_IDX: ctrl_q <= pwdata[7:0] & 8'h87;
            irq_ctrl_pkg::REG_SRCEN_IDX: src_en_q <= pwdata[7:0];
            irq_ctrl_pkg::REG_SRCLVL_IDX: src_lvl_q <= pwdata[15:0];
            irq_ctrl_pkg::REG_CLRMODE_IDX: begin
               autoclr_q <= pwdata[7:0];
               accclr_q <= pwdata[15:8];
            end
            irq_ctrl_pkg::REG_NMIEN_IDX: nmi_en_q <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // level enables act one cycle after the write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_en_dly_q <= 3'h0;
      end else begin
         lvl_en_dly_q <= ctrl_q[2:0];
      end
   end

   // ----------------------------------------------------------------
   // pending flags
   // ----------------------------------------------------------------
   logic ack_go, ack_nmi;
   logic [2:0] ack_src;
   logic [1:0] ack_lvl;
   logic [7:0] ack_vec;

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_pend
         logic clr;
         assign clr = (wr_done && idx == irq_ctrl_pkg::REG_PEND_IDX && pwdata[gi])
            || (ack_go && !ack_nmi && ack_src == 3'(gi) && autoclr_q[gi])
            || (rd_done && idx == irq_ctrl_pkg::REG_PEND_IDX && accclr_q[gi]);
         // set wins over any clear in the same cycle
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pend_q[gi] <= 1'b0;
            end else if (irq_cond[gi]) begin
               pend_q[gi] <= 1'b1;
            end else if (clr) begin
               pend_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // nonmaskable flags clear on entry only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_pend_q <= 2'h0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (nmi_cond[k]) begin
               nmi_pend_q[k] <= 1'b1;
            end else if (ack_go && ack_nmi && ack_src[0] == 1'(k)) begin
               nmi_pend_q[k] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // arbitration
   // ----------------------------------------------------------------
   logic [N-1:0] elig;
   logic [3:1] lvl_found;
   logic [2:0] lvl_win [3:1];
   logic [2:0] rr_start, cand;
   logic [1:0] cur_lvl, l;
   logic [7:0] rr_off;
   logic gate;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         l = src_lvl_q[2*i +: 2];
         elig[i] = pend_q[i] & src_en_q[i] & (l != irq_ctrl_pkg::LVL_OFF)
            & lvl_en_dly_q[l - 2'h1];
      end
   end

   // lowest vector first per level; low level may rotate past last served
   always_comb begin
      rr_off = prio_q - irq_ctrl_pkg::SRC_VEC_BASE;
      rr_start = 3'h0;
      if (ctrl_q[irq_ctrl_pkg::CTRL_RR_BIT] && prio_q >= irq_ctrl_pkg::SRC_VEC_BASE
          && rr_off < 8'(N)) begin
         rr_start = rr_off[2:0] + 3'h1;
      end
      lvl_found = 3'h0;
      for (int v = 1; v <= 3; v++) begin
         lvl_win[v] = 3'h0;
      end
      for (int v = 1; v <= 3; v++) begin
         for (int k = N - 1; k >= 0; k--) begin
            cand = (v == 1) ? rr_start + 3'(k) : 3'(k);
            if (elig[cand] && src_lvl_q[2*cand +: 2] == 2'(v)) begin
               lvl_found[v] = 1'b1;
               lvl_win[v] = cand;
            end
         end
      end
   end

   // running level from executing flags
   always_comb begin
      cur_lvl = 2'h0;
      if (exec_q[2]) begin
         cur_lvl = 2'h3;
      end else if (exec_q[1]) begin
         cur_lvl = 2'h2;
      end else if (exec_q[0]) begin
         cur_lvl = 2'h1;
      end
   end

   // instruction boundary with all blocking conditions lifted
   // the return edge itself never acknowledges, so its flag clear is not lost
   assign gate = state_q == irq_ctrl_pkg::ST_IDLE && core_instr_done && !ret_done_q
      && !after_ret_q && !core_lock_exec && ccp_cnt_q == 3'h0;

   // pick the winner against the running handler
   always_comb begin
      ack_go = 1'b0;
      ack_nmi = 1'b0;
      ack_src = 3'h0;
      ack_lvl = irq_ctrl_pkg::LVL_OFF;
      if (gate && !exec_q[3]) begin
         if (|(nmi_pend_q & nmi_en_q)) begin
            ack_go = 1'b1;
            ack_nmi = 1'b1;
            ack_src = (nmi_pend_q[0] & nmi_en_q[0]) ? 3'h0 : 3'h1;
         end else if (core_gie) begin
            for (int v = 1; v <= 3; v++) begin
               if (lvl_found[v] && 2'(v) > cur_lvl) begin
                  ack_go = 1'b1;
                  ack_src = lvl_win[v];
                  ack_lvl = 2'(v);
               end
            end
         end
      end
      ack_vec = ack_nmi ? irq_ctrl_pkg::NMI_VEC_BASE + {5'h00, ack_src}
         : irq_ctrl_pkg::SRC_VEC_BASE + {5'h00, ack_src};
   end

   // round-robin record of last low-level acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio_q <= irq_ctrl_pkg::PRIO_RST;
      end else if (wr_done && idx == irq_ctrl_pkg::REG_PRIO_IDX) begin
         prio_q <= pwdata[7:0];
      end else if (ack_go && ack_lvl == irq_ctrl_pkg::LVL_LOW
                   && ctrl_q[irq_ctrl_pkg::CTRL_RR_BIT]) begin
         prio_q <= ack_vec;
      end
   end

   // ----------------------------------------------------------------
   // executing flags and return bookkeeping
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_q <= 4'h0;
      end else if (ack_go) begin
         if (ack_nmi) begin
            exec_q[3] <= 1'b1;
         end else begin
            exec_q[ack_lvl - 2'h1] <= 1'b1;
         end
      end else if (ret_done_q) begin
         // drop only the topmost flag, the interrupted level resumes
         if (exec_q[3]) begin
            exec_q[3] <= 1'b0;
         end else if (cur_lvl != 2'h0) begin
            exec_q[cur_lvl - 2'h1] <= 1'b0;
         end
      end
   end

   // one instruction must retire after a return
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         after_ret_q <= 1'b0;
      end else if (ret_done_q) begin
         after_ret_q <= 1'b1;
      end else if (core_instr_done) begin
         after_ret_q <= 1'b0;
      end
   end

   // block window after a protected-register unlock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ccp_cnt_q <= 3'h0;
      end else if (core_ccp_unlock) begin
         ccp_cnt_q <= irq_ctrl_pkg::CCP_BLOCK_CYC;
      end else if (ccp_cnt_q != 3'h0) begin
         ccp_cnt_q <= ccp_cnt_q - 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // entry and return sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= irq_ctrl_pkg::ST_IDLE;
         cnt_q <= 8'h00;
         vec_q <= irq_ctrl_pkg::RESET_VEC;
         ack_q <= 1'b0;
         pc_load_q <= 1'b0;
         start_q <= 1'b0;
         ret_done_q <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         pc_load_q <= 1'b0;
         start_q <= 1'b0;
         ret_done_q <= 1'b0;
         case (state_q)
            irq_ctrl_pkg::ST_IDLE: begin
               if (ack_go) begin
                  ack_q <= 1'b1;
                  vec_q <= ack_vec;
                  if (core_sleep) begin
                     state_q <= irq_ctrl_pkg::ST_WAKE;
                     cnt_q <= irq_ctrl_pkg::WAKE_EXTRA_CYC + SLEEP_WAKE_CYC - 8'h01;
                  end else begin
                     state_q <= irq_ctrl_pkg::ST_PUSH;
                     cnt_q <= irq_ctrl_pkg::PUSH_CYC - 8'h01;
                  end
               end else if (core_irq_return_instr) begin
                  state_q <= irq_ctrl_pkg::ST_RET;
                  cnt_q <= (PC_WIDE ? irq_ctrl_pkg::RET_CYC_WIDE
                            : irq_ctrl_pkg::RET_CYC_NARROW) - 8'h01;
               end
            end
            irq_ctrl_pkg::ST_WAKE: begin
               if (cnt_q == 8'h00) begin
                  state_q <= irq_ctrl_pkg::ST_PUSH;
                  cnt_q <= irq_ctrl_pkg::PUSH_CYC - 8'h01;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            irq_ctrl_pkg::ST_PUSH: begin
               if (cnt_q == 8'h00) begin
                  state_q <= irq_ctrl_pkg::ST_JUMP;
                  cnt_q <= irq_ctrl_pkg::JUMP_CYC - 8'h01;
                  pc_load_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            irq_ctrl_pkg::ST_JUMP: begin
               if (cnt_q == 8'h00) begin
                  state_q <= irq_ctrl_pkg::ST_IDLE;
                  start_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            irq_ctrl_pkg::ST_RET: begin
               if (cnt_q == 8'h00) begin
                  state_q <= irq_ctrl_pkg::ST_IDLE;
                  ret_done_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: state_q <= irq_ctrl_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic busy_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_q != irq_ctrl_pkg::ST_IDLE && !(cnt_q == 8'h00
            && (state_q == irq_ctrl_pkg::ST_JUMP || state_q == irq_ctrl_pkg::ST_RET)))
            || ack_go || (state_q == irq_ctrl_pkg::ST_IDLE && core_irq_return_instr);
      end
   end
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq_ack = ack_q;
   assign irq_vec = vec_q;
   assign pc_load = pc_load_q;
   assign vec_addr = {7'h00, vec_q, 1'b0}; // word vectors, two words apart
   assign handler_start = start_q;
   assign ret_done = ret_done_q;
   assign seq_busy = busy_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_entry_push;
      irq_ack && !$past(core_sleep) ##2 pc_load;
   endsequence
   sequence s_entry_jump;
      pc_load ##3 handler_start;
   endsequence

   a_entry_push: assert property (irq_ack && !$past(core_sleep) |-> s_entry_push)
      else $error("vector load not two cycles after acknowledge");
   a_entry_jump: assert property (pc_load |-> s_entry_jump)
      else $error("handler start not three cycles after vector load");
   a_wake_delay: assert property (irq_ack && $past(core_sleep) |-> !pc_load[*8])
      else $error("wake-up entry too fast");
   a_ret_time: assert property (core_irq_return_instr && state_q == irq_ctrl_pkg::ST_IDLE && !ack_go
      |-> ##RET_DLY ret_done)
      else $error("return length wrong");
   a_gie_gate: assert property (ack_go && !ack_nmi |-> core_gie)
      else $error("maskable acknowledge without global enable");
   a_ccp_block: assert property (core_ccp_unlock |=> !ack_go[*4])
      else $error("acknowledge inside unlock window");
   a_nmi_alone: assert property (exec_q[3] |-> !ack_go)
      else $error("nonmaskable handler preempted");
   a_level_above: assert property (ack_go && !ack_nmi |-> ack_lvl > cur_lvl)
      else $error("acknowledge at or below running level");
   a_one_instr: assert property (ret_done || after_ret_q |-> !ack_go)
      else $error("acknowledge before one instruction retired");
   a_pend_set: assert property (irq_cond[0] |=> pend_q[0])
      else $error("pending flag lost on set");
   a_lvl_off: assert property (ack_go && !ack_nmi
      |-> src_lvl_q[2*ack_src +: 2] != irq_ctrl_pkg::LVL_OFF)
      else $error("source at level off acknowledged");
   a_lvl_en_dly: assert property ($fell(ctrl_q[0]) |=> !(ack_go
      && ack_lvl == irq_ctrl_pkg::LVL_LOW))
      else $error("low level acknowledged after enable cleared");
   a_rr_record: assert property (ack_go && ack_lvl == irq_ctrl_pkg::LVL_LOW
      && ctrl_q[irq_ctrl_pkg::CTRL_RR_BIT] && !wr_done |=> prio_q == $past(ack_vec))
      else $error("round-robin vector not recorded");

endmodule

// ---- verification/core_model.sv ----
// core stand-in: instruction boundaries and interrupt returns
// assumes: one pclk domain shared with the controller
module core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic handler_start,
   input wire logic seq_busy,
   input wire logic irq_ack,
   output logic core_instr_done,
   output logic core_irq_return_instr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;
   logic [3:0] run_q;
   // boundaries; slow mode stands for multicycle instructions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         core_instr_done <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         // no boundary just before or with a return, so no acknowledge can swallow it
         core_instr_done <= (!slow || cnt_q[1:0] == 2'h0) && cnt_q[3:1] != 3'h7;
      end
   end
   // every started handler ends with the interrupt return
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 4'h0;
         core_irq_return_instr <= 1'b0;
      end else if (handler_start) begin
         run_q <= run_q + 4'h1;
         core_irq_return_instr <= 1'b0;
      end else if (run_q != 4'h0 && cnt_q == 4'hF && !seq_busy && !irq_ack) begin
         run_q <= run_q - 4'h1;
         core_irq_return_instr <= 1'b1;
      end else begin
         core_irq_return_instr <= 1'b0;
      end
   end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench of the interrupt controller with a core stand-in
// assumes: controller and core_model compiled before this file
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, s;
   logic core_gie = 0, core_lock_exec = 0, core_ccp_unlock = 0, core_sleep = 0, slow = 0;
   logic [9:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [7:0] irq_cond = 0, irq_vec;
   logic [1:0] nmi_cond = 0;
   logic pready, pslverr, core_instr_done, core_irq_return_instr, irq_ack, pc_load, handler_start;
   logic ret_done, seq_busy;
   logic [15:0] vec_addr;
   int n_mismatch = 0, n_tests = 0, seed = 32'ha27f, a, b, la, lb, k, t;
   // clock, design and core
   always #10 pclk = ~pclk;
   multilevel_irq_ctrl u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .irq_cond, .nmi_cond, .core_gie, .core_instr_done,
      .core_irq_return_instr, .core_lock_exec, .core_ccp_unlock, .core_sleep, .irq_ack, .irq_vec,
      .pc_load, .vec_addr, .handler_start, .ret_done, .seq_busy);
   core_model u_core (.pclk, .presetn, .slow, .handler_start, .seq_busy, .irq_ack,
      .core_instr_done, .core_irq_return_instr);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is seen
   task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pulse(input logic [7:0] m, input logic [1:0] nm);
      @(posedge pclk);
      irq_cond <= m;
      nmi_cond <= nm;
      @(posedge pclk);
      irq_cond <= 8'h00;
      nmi_cond <= 2'h0;
   endtask
   task quiet(input int n);
      s = 1'b0;
      repeat (n) @(posedge pclk) s = s | irq_ack;
      chk(s, 0);
   endtask
   // acknowledge of vector v, then vector load and handler jump timing
   task wack(input logic [7:0] v);
      t = 0;
      do @(posedge pclk); while (irq_ack !== 1'b1 && ++t < 300);
      chk(irq_vec, v);
      chk(vec_addr, {v, 1'b0});
      chk(seq_busy, 1);
      // asleep: five extra cycles plus the default six-cycle wake time
      repeat (core_sleep ? 13 : 2) @(posedge pclk);
      chk(pc_load, 1);
      repeat (3) @(posedge pclk);
      chk(handler_start, 1);
   endtask
   function automatic logic [7:0] win(input int x, lx, y, ly);
      return (lx > ly || (lx == ly && x < y)) ? 8'(3 + x) : 8'(3 + y);
   endfunction
   task tally_and_finish;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge pclk);
      n_mismatch++;
      tally_and_finish;
   end
   // random pairs under low, medium and high levels, then level gating and nonmaskable order
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h02, 0);
      chk(rd, 0);
      apb(0, 8'h08, 0);
      chk(err, 1);
      apb(1, 8'h04, 32'hFF);
      apb(1, 8'h02, 32'h07);
      for (k = 0; k < 24; k++) begin
         slow <= k[0];
         a = {$random(seed)} % 8;
         b = (a + 1 + {$random(seed)} % 7) % 8;
         la = 1 + {$random(seed)} % 3;
         lb = 1 + {$random(seed)} % 3;
         apb(1, 8'h05, 32'((la << 2 * a) | (lb << 2 * b)));
         pulse(8'((1 << a) | (1 << b)), 2'h0);
         quiet(8);
         apb(0, 8'h03, 0);
         chk(rd, 32'((1 << a) | (1 << b)));
         core_gie <= 1'b1;
         wack(win(a, la, b, lb));
         wack(8'(6 + a + b) - win(a, la, b, lb));
         core_gie <= 1'b0;
         t = 0;
         do @(posedge pclk); while (ret_done !== 1'b1 && ++t < 60);
         chk(t < 60, 1);
         chk(seq_busy, 0);
         apb(0, 8'h03, 0);
         chk(rd, 0);
      end
      apb(1, 8'h05, 0);
      pulse(8'h01, 2'h0);
      core_gie <= 1'b1;
      quiet(20);
      apb(1, 8'h02, 2);
      apb(1, 8'h05, 3);
      quiet(20);
      apb(0, 8'h03, 0);
      chk(rd, 1);
      apb(1, 8'h03, 1);
      apb(0, 8'h03, 0);
      chk(rd, 0);
      // low-level round robin, lock and unlock windows
      apb(1, 8'h02, 32'h81);
      apb(1, 8'h05, 5);
      core_lock_exec <= 1'b1;
      pulse(8'h01, 2'h0);
      quiet(12);
      core_ccp_unlock <= 1'b1;
      @(posedge pclk);
      core_ccp_unlock <= 1'b0;
      core_lock_exec <= 1'b0;
      quiet(5);
      wack(8'h03);
      pulse(8'h03, 2'h0);
      wack(8'h04);
      wack(8'h03);
      core_gie <= 1'b0;
      apb(1, 8'h07, 3);
      core_sleep <= 1'b1;
      pulse(8'h00, 2'h3);
      wack(8'h01);
      core_sleep <= 1'b0;
      wack(8'h02);
      tally_and_finish;
   end
endmodule
